// file: common/abf_pkg.sv
package abf_pkg;

   // Data path widths
   localparam int ABF_WORD_W = 32;
   localparam int ABF_HALF_W = 16;
   localparam int ABF_BYTE_W = 8;

   // Single-precision field layout
   localparam int ABF_SIGN_POS = 31;
   localparam int ABF_EXP_MSB = 30;
   localparam int ABF_EXP_LSB = 23;
   localparam int ABF_FRAC_MSB = 22;

   // Exponent landmarks (biased)
   localparam logic [7:0] ABF_EXP_BIAS = 8'h7F;
   localparam logic [7:0] ABF_EXP_HALF = 8'h7E;
   localparam logic [7:0] ABF_EXP_MAX_SHIFT = 8'h9E;
   localparam logic [7:0] ABF_EXP_SPECIAL = 8'hFF;

   // Magnitude limits of a signed 32-bit result
   localparam logic [33:0] ABF_POS_LIMIT = 34'h0_7FFF_FFFF;
   localparam logic [33:0] ABF_NEG_LIMIT = 34'h0_8000_0000;

   // Reset values
   localparam logic [31:0] ABF_ACC_RESET = 32'h0000_0000;
   localparam logic ABF_FLAG_RESET = 1'b0;

   // Operations; conversions share the top code bit, rounding rule in the low bits
   typedef enum logic [2:0] {
      ABF_OP_IDLE = 3'b000,
      ABF_OP_SWAP_LOW = 3'b001,
      ABF_OP_REVERSE = 3'b010,
      ABF_OP_SPARE = 3'b011,
      ABF_OP_NEAREST = 3'b100,
      ABF_OP_TOWARD_ZERO = 3'b101,
      ABF_OP_CEILING = 3'b110,
      ABF_OP_FLOOR = 3'b111
   } abf_op_type;

   typedef enum logic [1:0] {
      ABF_RND_NEAREST = 2'b00,
      ABF_RND_ZERO = 2'b01,
      ABF_RND_CEILING = 2'b10,
      ABF_RND_FLOOR = 2'b11
   } abf_round_type;

endpackage

// file: logic/abf_float_to_int.sv
`timescale 1ns/1ps
`default_nettype none

module abf_float_to_int #(
   parameter int WIDTH = abf_pkg::ABF_WORD_W
) (
   input wire logic [WIDTH-1:0] float_value,
   input wire abf_pkg::abf_round_type round_mode,
   output logic [WIDTH-1:0] int_value,
   output logic fault
);
   import abf_pkg::*;

   generate
      if (WIDTH != ABF_WORD_W) begin : g_bad_width
         $error("abf_float_to_int serves single precision only");
      end
   endgenerate

   wire sign = float_value[ABF_SIGN_POS];
   wire [7:0] expo = float_value[ABF_EXP_MSB:ABF_EXP_LSB];
   wire [22:0] frac = float_value[ABF_FRAC_MSB:0];

   wire is_special = (expo == ABF_EXP_SPECIAL);
   wire below_one = (expo < ABF_EXP_BIAS);
   // Exponents past 2^31 cannot fit whatever the rounding
   wire too_big = (expo > ABF_EXP_MAX_SHIFT);
   wire [7:0] shift_full = expo - ABF_EXP_BIAS;
   wire [4:0] shift = shift_full[4:0];

   // Fixed point: 23 fraction bits below the binary point
   wire [55:0] scaled = {32'h0000_0000, 1'b1, frac} << shift;
   wire [32:0] int_part = below_one ? 33'h0_0000_0000 : scaled[55:23];
   wire half_bit = below_one ? (expo == ABF_EXP_HALF) : scaled[22];
   // Subnormals and all values below one half only feed the sticky part
   wire rest_bits = below_one ? ((expo == ABF_EXP_HALF) ? (|frac) : ((|expo) | (|frac)))
                              : (|scaled[21:0]);
   wire inexact = half_bit | rest_bits;

   logic round_up;
   always_comb begin
      case (round_mode)
         // RQ5 RQ6: nearest, ties to even
         ABF_RND_NEAREST: round_up = half_bit & (rest_bits | int_part[0]);
         // RQ7: drop the fraction
         ABF_RND_ZERO: round_up = 1'b0;
         // RQ8: toward plus infinity
         ABF_RND_CEILING: round_up = inexact & ~sign;
         // RQ9: toward minus infinity
         ABF_RND_FLOOR: round_up = inexact & sign;
         default: round_up = 1'b0;
      endcase
   end

   wire [33:0] magnitude = {1'b0, int_part} + {33'h0_0000_0000, round_up};
   // RQ10: the limit is checked after rounding
   wire range_bad = sign ? (magnitude > ABF_NEG_LIMIT) : (magnitude > ABF_POS_LIMIT);

   // RQ11: NaN and infinity are faults
   assign fault = is_special | too_big | range_bad;
   // RQ4: signed result
   assign int_value = sign ? (~magnitude[31:0] + 32'h0000_0001) : magnitude[31:0];

endmodule
`default_nettype wire

// file: logic/abf_accu_datapath.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1: Low-word swap exchanges the two low bytes of the primary accumulator.
// RQ2: Low-word swap keeps the upper half and the secondary accumulator.
// RQ3: Full swap reverses all four primary bytes; secondary untouched.
// RQ4: Conversions read the primary as single float, write signed 32-bit integer.
// RQ5: Nearest conversion yields the closest integer.
// RQ6: Nearest conversion picks the even integer on an exact half.
// RQ7: Toward-zero conversion keeps only the integer part.
// RQ8: Ceiling conversion yields smallest integer not below the input.
// RQ9: Floor conversion yields largest integer not above the input.
// RQ10: Out-of-range rounded result sets overflow and sticky overflow.
// RQ11: NaN or unrepresentable input skips the write and signals overflow.
// RQ12: Swaps touch no flags; conversions touch only the two overflow flags.
module abf_accu_datapath #(
   parameter int ACC_WIDTH = abf_pkg::ABF_WORD_W
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic op_valid,
   input wire abf_pkg::abf_op_type op_code,
   input wire logic primary_load,
   input wire logic [ACC_WIDTH-1:0] primary_load_data,
   input wire logic secondary_load,
   input wire logic [ACC_WIDTH-1:0] secondary_load_data,
   input wire logic sticky_clear,
   output logic [ACC_WIDTH-1:0] primary_accumulator,
   output logic [ACC_WIDTH-1:0] secondary_accumulator,
   output logic overflow_flag,
   output logic sticky_overflow_flag,
   output logic op_done,
   output logic op_fault
);
   import abf_pkg::*;

   generate
      if (ACC_WIDTH != ABF_WORD_W) begin : g_bad_width
         $error("abf_accu_datapath needs a 32-bit accumulator");
      end
   endgenerate

   function automatic logic [15:0] swap16(input logic [15:0] w);
      return {w[7:0], w[15:8]};
   endfunction

   function automatic logic [31:0] reverse32(input logic [31:0] w);
      return {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

   function automatic logic is_conversion(input abf_op_type op);
      return (op == ABF_OP_NEAREST) || (op == ABF_OP_TOWARD_ZERO) ||
             (op == ABF_OP_CEILING) || (op == ABF_OP_FLOOR);
   endfunction

   function automatic logic is_known(input abf_op_type op);
      return (op == ABF_OP_SWAP_LOW) || (op == ABF_OP_REVERSE) || is_conversion(op);
   endfunction

   wire take = clk_en & op_valid;
   wire take_swap_low = take & (op_code == ABF_OP_SWAP_LOW);
   wire take_reverse = take & (op_code == ABF_OP_REVERSE);
   wire take_conv = take & is_conversion(op_code);
   // A pending op owns the primary accumulator; a load beside it is dropped
   wire take_load = clk_en & primary_load & ~op_valid;

   wire [2:0] op_bits = op_code;
   wire abf_round_type round_mode = abf_round_type'(op_bits[1:0]);
   wire [ACC_WIDTH-1:0] conv_value;
   wire conv_fault;

   abf_float_to_int #(
      .WIDTH(ACC_WIDTH)
   ) u_convert (
      .float_value(primary_accumulator),
      .round_mode(round_mode),
      .int_value(conv_value),
      .fault(conv_fault)
   );

   // RQ1 RQ2: new low half, upper half carried over
   wire [ACC_WIDTH-1:0] swap_low_value = {primary_accumulator[ACC_WIDTH-1:ABF_HALF_W],
                                          swap16(primary_accumulator[ABF_HALF_W-1:0])};
   // RQ3: all four bytes reversed
   wire [ACC_WIDTH-1:0] reverse_value = reverse32(primary_accumulator);
   // RQ11: a faulting conversion leaves the accumulator as it was
   wire conv_write = take_conv & ~conv_fault;
   wire conv_overflow = take_conv & conv_fault;

   wire [ACC_WIDTH-1:0] next_primary =
      take_swap_low ? swap_low_value :
      take_reverse ? reverse_value :
      conv_write ? conv_value :
      take_load ? primary_load_data : primary_accumulator;
   // RQ2 RQ3 RQ12: no operation writes the secondary accumulator
   wire [ACC_WIDTH-1:0] next_secondary = (clk_en & secondary_load) ? secondary_load_data
                                                                   : secondary_accumulator;
   // RQ10 RQ12: only conversions write the overflow flag
   wire next_overflow = take_conv ? conv_fault : overflow_flag;
   // RQ10: a fault in the cycle of a clear still leaves the sticky flag set
   wire next_sticky = conv_overflow | (sticky_overflow_flag & ~(clk_en & sticky_clear));
   wire next_done = take & is_known(op_code);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         primary_accumulator <= ABF_ACC_RESET;
         secondary_accumulator <= ABF_ACC_RESET;
         overflow_flag <= ABF_FLAG_RESET;
         sticky_overflow_flag <= ABF_FLAG_RESET;
         op_done <= 1'b0;
         op_fault <= 1'b0;
      end else if (clk_en) begin
         primary_accumulator <= next_primary;
         secondary_accumulator <= next_secondary;
         overflow_flag <= next_overflow;
         sticky_overflow_flag <= next_sticky;
         op_done <= next_done;
         op_fault <= conv_overflow;
      end
   end

   // Field views of the primary accumulator, for the checks below
   wire acc_sign = primary_accumulator[ABF_SIGN_POS];
   wire [7:0] acc_expo = primary_accumulator[ABF_EXP_MSB:ABF_EXP_LSB];
   wire [22:0] acc_frac = primary_accumulator[ABF_FRAC_MSB:0];
   wire acc_nonzero = (acc_expo != 8'h00) || (acc_frac != 23'h00_0000);

   default clocking cb @(posedge mclk);
   endclocking

   default disable iff (!rst_n);

   AST_SWAP_LOW: assert property ( // RQ1
      take_swap_low |=> primary_accumulator[15:0] == swap16($past(primary_accumulator[15:0])))
      else $error("low-word swap gave wrong low half");

   AST_SWAP_KEEP: assert property ( // RQ2
      take_swap_low && !secondary_load && !sticky_clear |=>
         $stable(primary_accumulator[31:16]) && $stable(secondary_accumulator) &&
         $stable(overflow_flag) && $stable(sticky_overflow_flag) && op_done)
      else $error("low-word swap disturbed other state");

   AST_REVERSE: assert property ( // RQ3
      take_reverse && !secondary_load |=>
         primary_accumulator == reverse32($past(primary_accumulator)) &&
         $stable(secondary_accumulator) && $stable(overflow_flag))
      else $error("full swap gave wrong word");

   AST_CONV_WRITE: assert property ( // RQ4
      take_conv && !conv_fault && !secondary_load && !sticky_clear |=>
         op_done && !op_fault && !overflow_flag && $stable(sticky_overflow_flag) &&
         $stable(secondary_accumulator) && primary_accumulator == $past(conv_value))
      else $error("good conversion not written cleanly");

   AST_NEAREST_HALF: assert property ( // RQ5
      take && op_code == ABF_OP_NEAREST && !acc_sign && acc_expo == 8'h7E |=>
         primary_accumulator == (($past(acc_frac) == 23'h00_0000) ? 32'h0000_0000
                                                                  : 32'h0000_0001))
      else $error("nearest rounding of a value below one is wrong");

   AST_NEAREST_TIE: assert property ( // RQ6
      take && op_code == ABF_OP_NEAREST && primary_accumulator == 32'h4020_0000 |=>
         primary_accumulator == 32'h0000_0002 ##1 1'b1)
      else $error("tie 2.5 not rounded to even");

   AST_FLOAT_TO_INT_TOWARD_ZERO_NEG: assert property ( // RQ7
      take && op_code == ABF_OP_TOWARD_ZERO && primary_accumulator == 32'hBFC0_0000 |=>
         primary_accumulator == 32'hFFFF_FFFF && !overflow_flag)
      else $error("truncation of -1.5 is not -1");

   AST_CEIL_SMALL: assert property ( // RQ8
      take && op_code == ABF_OP_CEILING && !acc_sign && acc_expo < 8'h7F && acc_nonzero |=>
         primary_accumulator == 32'h0000_0001)
      else $error("ceiling of a small positive value is not 1");

   AST_FLOOR_SMALL: assert property ( // RQ9
      take && op_code == ABF_OP_FLOOR && acc_sign && acc_expo < 8'h7F && acc_nonzero |=>
         primary_accumulator == 32'hFFFF_FFFF)
      else $error("floor of a small negative value is not -1");

   AST_RANGE_FAULT: assert property ( // RQ10
      take_conv && !acc_sign && acc_expo >= 8'h9E |=>
         overflow_flag && sticky_overflow_flag && op_fault &&
         primary_accumulator == $past(primary_accumulator))
      else $error("positive out-of-range conversion not flagged");

   AST_MIN_INT: assert property ( // RQ10
      take_conv && primary_accumulator == 32'hCF00_0000 |=>
         primary_accumulator == 32'h8000_0000 && !overflow_flag && !op_fault)
      else $error("-2^31 must convert without overflow");

   AST_NAN_SKIP: assert property ( // RQ11
      take_conv && acc_expo == 8'hFF && acc_frac != 23'h00_0000 |=>
         overflow_flag && sticky_overflow_flag && $stable(primary_accumulator))
      else $error("NaN was converted or not flagged");

   AST_STICKY_HOLD: assert property ( // RQ12
      sticky_overflow_flag && !sticky_clear |=> sticky_overflow_flag)
      else $error("sticky overflow dropped without a clear");

   AST_FREEZE: assert property (
      !clk_en |=> $stable(primary_accumulator) && $stable(secondary_accumulator) &&
         $stable(overflow_flag) && $stable(sticky_overflow_flag) && $stable(op_done))
      else $error("state moved while the clock enable was low");

   AST_SPARE_NOP: assert property (
      take && (op_code == ABF_OP_IDLE || op_code == ABF_OP_SPARE) |=>
         !op_done && !op_fault && $stable(primary_accumulator) && $stable(overflow_flag))
      else $error("idle or spare code changed state");

   AST_LOAD_TAKEN: assert property (
      clk_en && primary_load && !op_valid |=> primary_accumulator == $past(primary_load_data))
      else $error("primary load did not land");

   AST_STICKY_CLEAR: assert property (
      clk_en && sticky_clear && !take_conv |=> !sticky_overflow_flag)
      else $error("sticky overflow survived a clear");

   AST_REVERSE_FLAGS: assert property ( // RQ12
      take_reverse && !sticky_clear |=>
         $stable(sticky_overflow_flag) && op_done && !op_fault)
      else $error("full swap touched the overflow flags");

   AST_NEG_RANGE: assert property ( // RQ10
      take_conv && acc_sign && acc_expo > 8'h9E |=>
         overflow_flag && sticky_overflow_flag && op_fault && $stable(primary_accumulator))
      else $error("negative out-of-range conversion not flagged");

   AST_FLOAT_TO_INT_TOWARD_ZERO_SMALL: assert property ( // RQ7
      take && op_code == ABF_OP_TOWARD_ZERO && acc_expo < 8'h7F |=>
         primary_accumulator == 32'h0000_0000)
      else $error("truncation of a value below one is not 0");

   AST_CEIL_NEG_SMALL: assert property ( // RQ8
      take && op_code == ABF_OP_CEILING && acc_sign && acc_expo < 8'h7F |=>
         primary_accumulator == 32'h0000_0000)
      else $error("ceiling of a small negative value is not 0");

   AST_FLOOR_POS_SMALL: assert property ( // RQ9
      take && op_code == ABF_OP_FLOOR && !acc_sign && acc_expo < 8'h7F |=>
         primary_accumulator == 32'h0000_0000)
      else $error("floor of a small positive value is not 0");

   AST_TIE_HUNDRED: assert property ( // RQ6
      take && op_code == ABF_OP_NEAREST && primary_accumulator == 32'h42C9_0000 |=>
         primary_accumulator == 32'h0000_0064)
      else $error("tie 100.5 not rounded to even");

   AST_CEIL_HUNDRED: assert property ( // RQ8
      take && op_code == ABF_OP_CEILING && primary_accumulator == 32'h42C9_0000 |=>
         primary_accumulator == 32'h0000_0065)
      else $error("ceiling of 100.5 is not 101");

   AST_FLOOR_HUNDRED: assert property ( // RQ9
      take && op_code == ABF_OP_FLOOR && primary_accumulator == 32'hC2C9_0000 |=>
         primary_accumulator == 32'hFFFF_FF9B)
      else $error("floor of -100.5 is not -101");

   COV_SWAP_LOW: cover property (take_swap_low ##1 op_done);
   COV_REVERSE: cover property (take_reverse ##1 op_done);
   COV_TIE: cover property (take && op_code == ABF_OP_NEAREST &&
      primary_accumulator == 32'h4020_0000);
   COV_FAULT_CLEAR: cover property (take_conv && conv_fault && sticky_clear);
   COV_STALL: cover property (!clk_en && op_valid ##1 clk_en && op_valid ##1 op_done);

endmodule
`default_nettype wire

// file: test/abf_seq_model.sv
`timescale 1ns/1ps
`default_nettype none

// Instruction sequencer stand-in: one queued operation per cycle, back to back while queued
// A request seen at a frozen edge is held, as a stalled sequencer would hold it
module abf_seq_model (
   input wire logic mclk,
   input wire logic clk_en,
   output logic op_valid,
   output var abf_pkg::abf_op_type op_code
);
   import abf_pkg::*;

   abf_op_type q[$];
   logic held;

   initial begin
      op_valid = 1'b0;
      op_code = ABF_OP_IDLE;
   end

   // Between requests the code wanders so a design that ignores op_valid gets caught
   always @(posedge mclk) begin
      held = op_valid & ~clk_en;
      #1;
      if (held) begin
         op_valid = 1'b1;
      end else if (q.size() > 0) begin
         op_valid = 1'b1;
         op_code = q.pop_front();
      end else begin
         op_valid = 1'b0;
         op_code = abf_op_type'(~op_code);
      end
   end

endmodule

`default_nettype wire

// file: test/test_accu_byte_swap_float_to_int.sv
`timescale 1ns/1ps
`default_nettype none

module test_accu_byte_swap_float_to_int;
   import abf_pkg::*;

   logic mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, op_valid, primary_load = 1'b0;
   logic secondary_load = 1'b0, sticky_clear = 1'b0;
   logic [31:0] primary_load_data = 32'h0, secondary_load_data = 32'h0;
   logic [31:0] primary_accumulator, secondary_accumulator, exp_p, exp_s, seed, v;
   logic overflow_flag, sticky_overflow_flag, op_done, op_fault, exp_ov, exp_st;
   abf_op_type op_code;
   int errors = 0, check_count = 0;
   logic [31:0] tbl[16] = '{32'h4020_0000, 32'hC020_0000, 32'h4060_0000, 32'h42C9_0000,
      32'hC2C9_0000, 32'h3F00_0000, 32'h8000_0000, 32'h7FC0_0000, 32'h7F80_0000,
      32'h4F00_0000, 32'hCF00_0000, 32'h4EFF_FFFF, 32'h3FC0_0000, 32'hBFC0_0000,
      32'hBF40_0000, 32'hCF80_0000};

   always #2 mclk = ~mclk;

   abf_seq_model SEQ (.mclk(mclk), .clk_en(clk_en), .op_valid(op_valid), .op_code(op_code));

   abf_accu_datapath DUT (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .op_valid(op_valid),
      .op_code(op_code), .primary_load(primary_load), .primary_load_data(primary_load_data),
      .secondary_load(secondary_load), .secondary_load_data(secondary_load_data),
      .sticky_clear(sticky_clear), .primary_accumulator(primary_accumulator),
      .secondary_accumulator(secondary_accumulator), .overflow_flag(overflow_flag),
      .sticky_overflow_flag(sticky_overflow_flag), .op_done(op_done), .op_fault(op_fault));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0);
   endfunction

   function automatic logic [31:0] swp(input logic [31:0] p, input logic [2:0] c);
      if (c == 3'h1) return {p[31:16], p[7:0], p[15:8]};
      if (c == 3'h2) return {p[7:0], p[15:8], p[23:16], p[31:24]};
      return p;
   endfunction

   // Result is {fault, value}; magnitude kept in 64 bits so range faults are exact
   function automatic logic [32:0] f2i(input logic [31:0] f, input logic [1:0] md);
      logic [63:0] m, ip;
      logic half, stk, inc;
      int e, s;
      e = f[30:23];
      m = {40'h0, e != 0, f[22:0]};
      if (e == 255 || e > 190) return {1'b1, 32'h0};
      if (e == 0) e = 1;
      s = 150 - e;
      if (s <= 0) begin
         ip = m << (-s);
         half = 1'b0;
         stk = 1'b0;
      end else if (s >= 64) begin
         ip = 64'h0;
         half = 1'b0;
         stk = m != 64'h0;
      end else begin
         ip = m >> s;
         half = m[s-1];
         stk = (m & ((64'h1 << (s - 1)) - 64'h1)) != 64'h0;
      end
      case (md)
         2'h0: inc = half && (stk || ip[0]);
         2'h1: inc = 1'b0;
         2'h2: inc = !f[31] && (half || stk);
         default: inc = f[31] && (half || stk);
      endcase
      ip = ip + {63'h0, inc};
      if (f[31] ? ip > 64'h8000_0000 : ip > 64'h7FFF_FFFF) return {1'b1, 32'h0};
      return {1'b0, f[31] ? ~ip[31:0] + 32'h1 : ip[31:0]};
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic check_state();
      check("primary", primary_accumulator, exp_p);
      check("secondary", secondary_accumulator, exp_s);
      check("overflow", {31'h0, overflow_flag}, {31'h0, exp_ov});
      check("sticky", {31'h0, sticky_overflow_flag}, {31'h0, exp_st});
   endtask

   task automatic do_reset();
      @(posedge mclk);
      #1 rst_n = 1'b0;
      repeat (8) @(posedge mclk);
      #1 rst_n = 1'b1;
      {exp_p, exp_s, exp_ov, exp_st} = '0;
      check_state();
      check("done", {31'h0, op_done}, 32'h0);
   endtask

   task automatic load(input logic [31:0] p, input logic [31:0] s);
      @(posedge mclk);
      #1 {primary_load, secondary_load, primary_load_data, secondary_load_data} = {2'b11, p, s};
      @(posedge mclk);
      #1 {primary_load, secondary_load} = 2'b00;
      exp_p = p;
      exp_s = s;
   endtask

   // A load offered alongside an operation must be dropped
   task automatic run_op(input logic [2:0] c, input logic sc, input logic ld);
      logic [32:0] r;
      logic known, ef;
      known = c != 3'h0 && c != 3'h3;
      r = f2i(exp_p, c[1:0]);
      ef = c[2] && r[32];
      // Queued on the edge so the model picks it up 1 ns later, never earlier
      @(posedge mclk);
      SEQ.q.push_back(abf_op_type'(c));
      #1 {sticky_clear, primary_load, primary_load_data} = {sc, ld, ~exp_p};
      @(posedge mclk);
      #1 {sticky_clear, primary_load} = 2'b00;
      exp_p = swp(exp_p, c);
      if (c[2] && !r[32]) exp_p = r[31:0];
      if (c[2]) exp_ov = r[32];
      exp_st = ef | (exp_st & !sc);
      check("done", {31'h0, op_done}, {31'h0, known});
      check("fault", {31'h0, op_fault}, {31'h0, ef});
      check_state();
      @(posedge mclk);
      #1 check("done_end", {30'h0, op_done, op_fault}, 32'h0);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      final_report();
   end

   initial begin
      seed = 32'h3296FA02;
      do_reset();
      load(32'h1122_3344, 32'hA5A5_5A5A);
      run_op(3'h1, 1'b0, 1'b1);
      run_op(3'h2, 1'b0, 1'b0);
      run_op(3'h0, 1'b0, 1'b1);
      run_op(3'h3, 1'b0, 1'b0);
      // Back-to-back ops each see the previous result
      SEQ.q.push_back(ABF_OP_SWAP_LOW);
      SEQ.q.push_back(ABF_OP_REVERSE);
      SEQ.q.push_back(ABF_OP_SWAP_LOW);
      repeat (5) @(posedge mclk);
      exp_p = swp(swp(swp(exp_p, 3'h1), 3'h2), 3'h1);
      #1 check_state();
      $display("swap tests done");
      // every rounding mode over halves, signs and range edges
      for (int md = 4; md < 8; md++) begin
         foreach (tbl[i]) begin
            load(tbl[i], ~tbl[i]);
            run_op(md[2:0], 1'b0, 1'b0);
         end
      end
      load(32'h7FC0_0000, 32'h0);
      run_op(3'h4, 1'b1, 1'b0);
      load(32'h3FC0_0000, 32'h0);
      run_op(3'h5, 1'b1, 1'b0);
      $display("conversion tests done");
      // Request offered while frozen must wait and land once the enable returns
      @(posedge mclk);
      SEQ.q.push_back(ABF_OP_REVERSE);
      #1 clk_en = 1'b0;
      repeat (3) @(posedge mclk);
      #1 clk_en = 1'b1;
      check_state();
      check("done", {31'h0, op_done}, 32'h0);
      @(posedge mclk);
      exp_p = swp(exp_p, 3'h2);
      #1 check_state();
      check("done", {31'h0, op_done}, 32'h1);
      $display("stall test done");
      repeat (80) begin
         seed = lfsr(seed);
         v = seed;
         if (v[0]) v[30:23] = 8'h7C + {3'h0, v[5:1]};
         seed = lfsr(seed);
         load(v, seed);
         seed = lfsr(seed);
         run_op(seed[2:0], seed[3] & seed[4], seed[5]);
      end
      $display("random tests done");
      do_reset();
      final_report();
   end

endmodule

`default_nettype wire
